// ==== hdl/dual_wiper_serial_command_unit.sv ====
// What this block does
// - Log increment shifts the wiper one bit left, doubling it.
// - Log increment of zero gives code one.
// - Log increment at midscale or above gives full scale and stays there.
// - Log decrement shifts right dropping the LSB; zero stays zero.
// - Code 12 log-increments the addressed wiper, code 13 both wipers.
// - Code 4 log-decrements the addressed wiper, code 5 both wipers.
// - Address 0 and 1 are wiper presets, 2 to 14 user, 15 reserved.
// - Addresses 2 through 14 are free user storage.
// - Presets load into wipers at reset, command 1, command 8, strobe.
// - User words hold 16 bits; command 3 writes, command 9 reads.
// - Command 1 enters read power state; command 0 returns to idle.
// - SDO returns wiper after 10, stored word after 9, else chains.
// - Command executes when chip select rises after a full frame.
// - SDO is open drain and released while chip select is high.
// - Slave works in CPOL 0 CPHA 0 and CPOL 1 CPHA 1.
// - Frames are 24 bits, most significant bit first.
// - Frame is command field, address field, then data field.
// - Lowest address bit picks wiper one or two.
// - Each wiper decodes to exactly one of 1024 taps.
// - Preset strobe and write protect inputs are active low.
// - Remaining command codes decode to their documented operations.
// - During a save the shift register is locked; ready pin shows done.
// - Write protect blocks wiper changes except restores and strobe.
// - Strobe low holds midscale; presets load when strobe returns high.
`timescale 1ns/1ps
module dual_wiper_serial_command_unit #(
    parameter int unsigned NV_SAVE_CYCLES = wiper_pkg::NV_SAVE_CYCLES_DEF
) (
    input  wire logic                             clock,
    input  wire logic                             resetn,
    input  wire logic                             spi_clk,
    input  wire logic                             cs_n,
    input  wire logic                             sdi,
    output logic                                  sdo_out,
    output logic                                  sdo_oe_n,
    output logic                                  ready_out,
    output logic                                  ready_oe_n,
    input  wire logic                             preset_strobe_n,
    input  wire logic                             write_protect_n,
    output logic [wiper_pkg::WIPER_W-1:0]         wiper1_code,
    output logic [wiper_pkg::WIPER_W-1:0]         wiper2_code,
    output logic [wiper_pkg::TAP_COUNT-1:0]       wiper1_taps,
    output logic [wiper_pkg::TAP_COUNT-1:0]       wiper2_taps,
    output logic                                  read_power_mode,
    output logic                                  save_busy
);
    import wiper_pkg::*;

    localparam logic [SAVE_CNT_W-1:0] SAVE_LAST = SAVE_CNT_W'(NV_SAVE_CYCLES - 1);
    localparam logic [TAP_COUNT-1:0]  TAP_ONE   = {{(TAP_COUNT-1){1'b0}}, 1'b1};

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    sys_state_s  s_r;
    sys_state_s  s_nxt;
    link_state_s link_r;
    link_state_s link_nxt;

    logic [4:0]  bit_cnt_r;
    logic [4:0]  bit_cnt_nxt;
    logic [4:0]  rb_idx;
    logic        link_frame_rst_n;
    logic        sdo_bit;

    frame_s      frm;
    step_op_e    op_kind;
    step_op_e    op1;
    step_op_e    op2;
    logic        gang;
    logic        sel2;
    logic [9:0]  step1;
    logic [9:0]  step2;

    logic        execute;
    logic        frame_new;
    logic        cs_rise;
    logic        wp_on;
    logic        pr_low;
    logic        pr_rise;

    logic [3:0]  preset_addr;
    logic [15:0] nv_read;

    // ------------------------------------------------------------------
    // Link domain: serial shift register on the serial clock
    // ------------------------------------------------------------------
    // Both supported modes sample on the rising edge, so one edge serves both
    always_comb begin
        link_nxt           = link_r;
        link_nxt.busy_sync = {link_r.busy_sync[0], s_r.state == ST_SAVE};
        if (!link_r.busy_sync[1] && !cs_n) begin
            link_nxt.sr = {link_r.sr[22:0], sdi};
            if (bit_cnt_r == FRAME_LAST_BIT) begin
                link_nxt.frame_tog = ~link_r.frame_tog;
            end
        end
    end

    always_ff @(posedge spi_clk or negedge resetn) begin
        if (!resetn) begin
            link_r <= '0;
        end else begin
            link_r <= link_nxt;
        end
    end

    // The serial clock stops between frames, so the bit count is cleared by chip select itself
    assign link_frame_rst_n = resetn & ~cs_n;

    always_comb begin
        bit_cnt_nxt = bit_cnt_r;
        if (bit_cnt_r != FRAME_BITS && !link_r.busy_sync[1]) begin
            bit_cnt_nxt = bit_cnt_r + 5'h01;
        end
    end

    always_ff @(posedge spi_clk or negedge link_frame_rst_n) begin
        if (!link_frame_rst_n) begin
            bit_cnt_r <= '0;
        end else begin
            bit_cnt_r <= bit_cnt_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Serial output
    // ------------------------------------------------------------------
    // Readback words change only while chip select is high, so they are steady during a frame
    assign rb_idx  = FRAME_LAST_BIT - bit_cnt_r;
    assign sdo_bit = (s_r.rb_valid && bit_cnt_r < FRAME_BITS) ? s_r.rb_word[rb_idx]
                                                               : link_r.sr[23];
    assign sdo_out  = 1'b0;
    assign sdo_oe_n = cs_n | sdo_bit;

    // ------------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------------
    // The shift register is only read while chip select is high and the serial clock idle
    assign frm         = frame_s'(link_r.sr);
    assign sel2        = frm.address_field[0];
    assign preset_addr = {3'h0, sel2};
    assign nv_read     = s_r.nv[frm.address_field];

    assign wp_on       = ~s_r.wp_sync[1];
    assign pr_low      = ~s_r.pr_sync[1];
    assign pr_rise     = s_r.pr_sync[1] & ~s_r.pr_prev;

    assign cs_rise     = s_r.cs_sync[1] & ~s_r.cs_prev;
    assign frame_new   = s_r.tog_sync[1] != s_r.tog_seen;
    assign execute     = cs_rise & frame_new;

    always_comb begin
        op_kind = STEP_NONE;
        gang    = 1'b0;
        case (frm.command_field)
            CMD_LOG_DEC, CMD_LOG_DEC_ALL: begin
                op_kind = STEP_LOG_DOWN;
            end

            CMD_DEC, CMD_DEC_ALL: begin
                op_kind = STEP_DOWN;
            end

            CMD_LOG_INC, CMD_LOG_INC_ALL: begin
                op_kind = STEP_LOG_UP;
            end

            CMD_INC, CMD_INC_ALL: begin
                op_kind = STEP_UP;
            end

            default: begin
                op_kind = STEP_NONE;
            end
        endcase

        if (frm.command_field == CMD_LOG_DEC_ALL || frm.command_field == CMD_DEC_ALL ||
            frm.command_field == CMD_LOG_INC_ALL || frm.command_field == CMD_INC_ALL) begin
            gang = 1'b1;
        end
        op1 = (gang || !sel2) ? op_kind : STEP_NONE;
        op2 = (gang || sel2) ? op_kind : STEP_NONE;
    end

    wiper_step u_step1 (
        .op        (op1),
        .cur_code  (s_r.wiper1),
        .next_code (step1)
    );

    wiper_step u_step2 (
        .op        (op2),
        .cur_code  (s_r.wiper2),
        .next_code (step2)
    );

    // ------------------------------------------------------------------
    // System domain: execution, store and strobe
    // ------------------------------------------------------------------
    always_comb begin
        s_nxt          = s_r;
        s_nxt.cs_sync  = {s_r.cs_sync[0], cs_n};
        s_nxt.pr_sync  = {s_r.pr_sync[0], preset_strobe_n};
        s_nxt.wp_sync  = {s_r.wp_sync[0], write_protect_n};
        s_nxt.tog_sync = {s_r.tog_sync[0], link_r.frame_tog};
        s_nxt.cs_prev  = s_r.cs_sync[1];
        s_nxt.pr_prev  = s_r.pr_sync[1];

        if (execute) begin
            s_nxt.tog_seen = s_r.tog_sync[1];
        end

        case (s_r.state)
            ST_INIT: begin
                s_nxt.wiper1 = s_r.nv[ADDR_PRESET1][9:0];
                s_nxt.wiper2 = s_r.nv[ADDR_PRESET2][9:0];
                s_nxt.state  = ST_IDLE;
            end

            ST_IDLE: begin
                if (execute) begin
                    s_nxt.rb_valid = 1'b0;
                    case (frm.command_field)
                        CMD_IDLE: begin
                            s_nxt.read_mode = 1'b0;
                        end

                        CMD_RESTORE: begin
                            s_nxt.read_mode = 1'b1;
                            if (sel2) begin
                                s_nxt.wiper2 = s_r.nv[preset_addr][9:0];
                            end else begin
                                s_nxt.wiper1 = s_r.nv[preset_addr][9:0];
                            end
                        end

                        CMD_RESET_PRESET: begin
                            s_nxt.wiper1 = s_r.nv[ADDR_PRESET1][9:0];
                            s_nxt.wiper2 = s_r.nv[ADDR_PRESET2][9:0];
                        end

                        CMD_SAVE_WIPER: begin
                            if (!wp_on) begin
                                s_nxt.save_addr = preset_addr;
                                s_nxt.save_data = {6'h00, sel2 ? s_r.wiper2 : s_r.wiper1};
                                s_nxt.save_cnt  = '0;
                                s_nxt.state     = ST_SAVE;
                            end
                        end

                        CMD_SAVE_WORD: begin
                            // Presets keep only the low ten bits when used as wiper codes
                            if (!wp_on && frm.address_field != ADDR_RESERVED) begin
                                s_nxt.save_addr = frm.address_field;
                                s_nxt.save_data = frm.data_field;
                                s_nxt.save_cnt  = '0;
                                s_nxt.state     = ST_SAVE;
                            end
                        end

                        CMD_READ_NV: begin
                            s_nxt.rb_valid = 1'b1;
                            s_nxt.rb_word  = '{frm.command_field, frm.address_field, nv_read};
                        end

                        CMD_READ_WIPER: begin
                            s_nxt.rb_valid = 1'b1;
                            s_nxt.rb_word  = '{frm.command_field, frm.address_field,
                                              {6'h00, sel2 ? s_r.wiper2 : s_r.wiper1}};
                        end

                        CMD_WRITE_WIPER: begin
                            if (!wp_on) begin
                                if (sel2) begin
                                    s_nxt.wiper2 = frm.data_field[9:0];
                                end else begin
                                    s_nxt.wiper1 = frm.data_field[9:0];
                                end
                            end
                        end

                        default: begin
                            if (!wp_on) begin
                                s_nxt.wiper1 = step1;
                                s_nxt.wiper2 = step2;
                            end
                        end
                    endcase
                end
            end

            ST_SAVE: begin
                // Frames arriving during a save are dropped; the store commits at the end
                if (s_r.save_cnt >= SAVE_LAST) begin
                    s_nxt.nv[s_r.save_addr] = s_r.save_data;
                    s_nxt.state             = ST_IDLE;
                end else begin
                    s_nxt.save_cnt = s_r.save_cnt + 1'b1;
                end
            end

            default: begin
                s_nxt.state = ST_IDLE;
            end
        endcase
        if (pr_low) begin
            s_nxt.wiper1 = WIPER_MID;
            s_nxt.wiper2 = WIPER_MID;
        end else if (pr_rise) begin
            s_nxt.wiper1 = s_r.nv[ADDR_PRESET1][9:0];
            s_nxt.wiper2 = s_r.nv[ADDR_PRESET2][9:0];
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            s_r <= SYS_RESET;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign wiper1_code     = s_r.wiper1;
    assign wiper2_code     = s_r.wiper2;

    assign wiper1_taps     = TAP_ONE << s_r.wiper1;
    assign wiper2_taps     = TAP_ONE << s_r.wiper2;

    assign read_power_mode = s_r.read_mode;
    assign save_busy       = s_r.state == ST_SAVE;
    assign ready_out       = 1'b0;
    assign ready_oe_n      = ~save_busy;

endmodule : dual_wiper_serial_command_unit

// ==== hdl/wiper_pkg.sv ====
package wiper_pkg;

    // ------------------------------------------------------------------
    // Sizes and codes
    // ------------------------------------------------------------------
    localparam int           WIPER_W         = 10;
    localparam int           TAP_COUNT       = 1024;
    localparam int           NV_DEPTH        = 16;
    localparam int           DATA_W          = 16;
    localparam int           SAVE_CNT_W      = 23;
    localparam logic [4:0]   FRAME_BITS      = 5'h18;
    localparam logic [4:0]   FRAME_LAST_BIT  = 5'h17;
    localparam logic [9:0]   WIPER_ZERO      = 10'h000;
    localparam logic [9:0]   WIPER_ONE       = 10'h001;
    localparam logic [9:0]   WIPER_MID       = 10'h200;
    localparam logic [9:0]   WIPER_FULL      = 10'h3ff;
    localparam logic [3:0]   ADDR_PRESET1    = 4'h0;
    localparam logic [3:0]   ADDR_PRESET2    = 4'h1;
    localparam logic [3:0]   ADDR_USER_FIRST = 4'h2;
    localparam logic [3:0]   ADDR_USER_LAST  = 4'he;
    localparam logic [3:0]   ADDR_RESERVED   = 4'hf;
    localparam logic [15:0]  NV_PRESET_RESET = 16'h0200;
    localparam logic [15:0]  NV_USER_RESET   = 16'h0000;
    localparam logic [15:0][15:0] NV_RESET   = {{14{NV_USER_RESET}}, NV_PRESET_RESET, NV_PRESET_RESET};

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLOCK_MHZ          = 200;
    localparam int NV_SAVE_MS         = 25;
    localparam int NV_SAVE_CYCLES_DEF = NV_SAVE_MS * CLOCK_MHZ * 1000;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        CMD_IDLE         = 4'h0,
        CMD_RESTORE      = 4'h1,
        CMD_SAVE_WIPER   = 4'h2,
        CMD_SAVE_WORD    = 4'h3,
        CMD_LOG_DEC      = 4'h4,
        CMD_LOG_DEC_ALL  = 4'h5,
        CMD_DEC          = 4'h6,
        CMD_DEC_ALL      = 4'h7,
        CMD_RESET_PRESET = 4'h8,
        CMD_READ_NV      = 4'h9,
        CMD_READ_WIPER   = 4'ha,
        CMD_WRITE_WIPER  = 4'hb,
        CMD_LOG_INC      = 4'hc,
        CMD_LOG_INC_ALL  = 4'hd,
        CMD_INC          = 4'he,
        CMD_INC_ALL      = 4'hf
    } cmd_e;

    typedef enum logic [2:0] {
        STEP_NONE     = 3'h0,
        STEP_LOG_UP   = 3'h1,
        STEP_LOG_DOWN = 3'h2,
        STEP_UP       = 3'h3,
        STEP_DOWN     = 3'h4
    } step_op_e;

    typedef enum logic [2:0] {
        ST_INIT = 3'b001,
        ST_IDLE = 3'b010,
        ST_SAVE = 3'b100
    } unit_state_e;

    typedef struct packed {
        cmd_e        command_field;
        logic [3:0]  address_field;
        logic [15:0] data_field;
    } frame_s;

    typedef struct packed {
        unit_state_e           state;
        logic [1:0]            cs_sync;
        logic                  cs_prev;
        logic [1:0]            pr_sync;
        logic                  pr_prev;
        logic [1:0]            wp_sync;
        logic [1:0]            tog_sync;
        logic                  tog_seen;
        logic [9:0]            wiper1;
        logic [9:0]            wiper2;
        logic [15:0][15:0]     nv;
        logic [3:0]            save_addr;
        logic [15:0]           save_data;
        logic [SAVE_CNT_W-1:0] save_cnt;
        logic                  read_mode;
        logic                  rb_valid;
        frame_s                rb_word;
    } sys_state_s;

    typedef struct packed {
        logic [23:0] sr;
        logic [1:0]  busy_sync;
        logic        frame_tog;
    } link_state_s;

    localparam sys_state_s SYS_RESET = '{
        state:     ST_INIT,
        cs_sync:   2'h3,
        cs_prev:   1'b1,
        pr_sync:   2'h3,
        pr_prev:   1'b1,
        wp_sync:   2'h3,
        wiper1:    WIPER_MID,
        wiper2:    WIPER_MID,
        nv:        NV_RESET,
        default:   '0
    };

endpackage : wiper_pkg

// ==== hdl/wiper_step.sv ====
`timescale 1ns/1ps
module wiper_step (
    input  wiper_pkg::step_op_e op,
    input  wire logic [9:0]     cur_code,
    output logic [9:0]          next_code
);
    import wiper_pkg::*;

    // ------------------------------------------------------------------
    // Shift and step arithmetic for one wiper
    // ------------------------------------------------------------------
    always_comb begin
        next_code = cur_code;
        case (op)
            STEP_LOG_UP: begin
                if (cur_code == WIPER_ZERO) begin
                    next_code = WIPER_ONE;
                end else if (cur_code >= WIPER_MID) begin
                    next_code = WIPER_FULL;
                end else begin
                    next_code = {cur_code[8:0], 1'b0};
                end
            end
            STEP_LOG_DOWN: begin
                // Odd codes lose their LSB; zero stays zero
                next_code = {1'b0, cur_code[9:1]};
            end
            STEP_UP: begin
                if (cur_code != WIPER_FULL) begin
                    next_code = cur_code + WIPER_ONE;
                end
            end
            STEP_DOWN: begin
                if (cur_code != WIPER_ZERO) begin
                    next_code = cur_code - WIPER_ONE;
                end
            end
            default: begin
                next_code = cur_code;
            end
        endcase
    end

endmodule : wiper_step

// ==== verif/dual_wiper_serial_command_unit_asserts.sv ====
`timescale 1ns/1ps
module dual_wiper_serial_command_unit_asserts #(
    parameter int unsigned NV_SAVE_CYCLES = 8
) (
    input wire logic                           clock,
    input wire logic                           resetn,
    input wire logic                           spi_clk,
    input wire logic                           cs_n,
    input wire logic                           sdi,
    input wire logic                           sdo_out,
    input wire logic                           sdo_oe_n,
    input wire logic                           ready_out,
    input wire logic                           ready_oe_n,
    input wire logic                           preset_strobe_n,
    input wire logic                           write_protect_n,
    input wire logic [wiper_pkg::WIPER_W-1:0]   wiper1_code,
    input wire logic [wiper_pkg::WIPER_W-1:0]   wiper2_code,
    input wire logic [wiper_pkg::TAP_COUNT-1:0] wiper1_taps,
    input wire logic [wiper_pkg::TAP_COUNT-1:0] wiper2_taps,
    input wire logic                           read_power_mode,
    input wire logic                           save_busy
);
    import wiper_pkg::*;
    logic [31:0] cnt_r, cnt_nxt;
    // ----
    // Save length counter
    // ----
    always_comb cnt_nxt = save_busy ? cnt_r + 32'h1 : 32'h0;
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) cnt_r <= '0;
        else cnt_r <= cnt_nxt;
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    a_sdo_release: assert property (cs_n |-> sdo_oe_n)
        else $error("sdo driven while deselected");
    a_od_levels: assert property (!sdo_out && !ready_out)
        else $error("open drain level not low");
    a_ready_busy: assert property (save_busy == !ready_oe_n)
        else $error("ready pin disagrees with busy");
    a_tap_one: assert property (wiper1_taps == (TAP_COUNT'(1) << wiper1_code))
        else $error("wiper1 tap decode wrong");
    a_tap_two: assert property (wiper2_taps == (TAP_COUNT'(1) << wiper2_code))
        else $error("wiper2 tap decode wrong");
    a_save_length: assert property ($fell(save_busy) |-> cnt_r == NV_SAVE_CYCLES)
        else $error("save time wrong");
    a_strobe_mid: assert property (!preset_strobe_n [*5] |-> wiper1_code == WIPER_MID && wiper2_code == WIPER_MID)
        else $error("strobe low not midscale");
    a_frame_hold: assert property (!cs_n && !$past(cs_n, 6) && preset_strobe_n && $past(preset_strobe_n, 6)
        |-> $stable(wiper1_code) && $stable(wiper2_code))
        else $error("wiper moved mid frame");
    a_mode_after_cs: assert property ($changed(read_power_mode) |-> cs_n && $past(cs_n, 2))
        else $error("power mode moved without frame end");
    a_save_after_cs: assert property ($rose(save_busy) |-> cs_n && $past(cs_n, 2))
        else $error("save began without frame end");
    c_save: cover property ($rose(save_busy));
    c_mode: cover property ($rose(read_power_mode));
    c_full: cover property (wiper2_code == WIPER_FULL);
    c_strobe: cover property ($fell(preset_strobe_n));
endmodule : dual_wiper_serial_command_unit_asserts

// ==== verif/dual_wiper_serial_command_unit_bench.sv ====
`timescale 1ns/1ps
module dual_wiper_serial_command_unit_bench;
    import wiper_pkg::*;
    logic          clock = 1'b0, resetn = 1'b0, strobe_n = 1'b1, wp_n = 1'b1, pol = 1'b0;
    logic          spi_clk, cs_n, sdi, sdo_out, sdo_oe_n, ready_out, ready_oe_n, rpm, busy;
    logic [9:0]    w1, w2, e;
    logic [1023:0] t1, t2;
    logic [47:0]   rx;
    int            errors = 0, n_compared = 0, cycles = 0;
    always #2.5 clock = ~clock;
    dual_wiper_serial_command_unit #(.NV_SAVE_CYCLES(8)) dut_u (.clock(clock), .resetn(resetn),
        .spi_clk(spi_clk), .cs_n(cs_n), .sdi(sdi), .sdo_out(sdo_out), .sdo_oe_n(sdo_oe_n),
        .ready_out(ready_out), .ready_oe_n(ready_oe_n), .preset_strobe_n(strobe_n),
        .write_protect_n(wp_n), .wiper1_code(w1), .wiper2_code(w2), .wiper1_taps(t1),
        .wiper2_taps(t2), .read_power_mode(rpm), .save_busy(busy));
    spi_master_model m_u (.clock(clock), .sdo_out(sdo_out), .sdo_oe_n(sdo_oe_n), .spi_clk(spi_clk),
        .cs_n(cs_n), .sdi(sdi));
    // ----
    // Tasks
    // ----
    task automatic check_val(input string what, input logic [23:0] exp, input logic [23:0] got);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : check_val
    task automatic send(input logic [23:0] w);
        m_u.xfer({24'h0, w}, 24, pol, rx);
    endtask : send
    task automatic done(input string s);
        $display("end of test %s", s);
    endtask : done
    task automatic wrap_up;
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : wrap_up
    // Save must be running once the frame returns; then wait at most 30 cycles for it to end, unchecked
    task automatic save_wait;
        check_val("busy ready", 24'h2, {22'h0, busy, ready_oe_n});
        for (int i = 0; i < 30 && busy !== 1'b0; i++) @(posedge clock);
    endtask : save_wait
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 80000) begin
            errors++;
            wrap_up;
        end
    end
    // ----
    // Tests
    // ----
    initial begin
        repeat (3) @(posedge clock);
        resetn <= 1'b1;
        repeat (6) @(posedge clock);
        #1;
        check_val("wipers", {4'h0, WIPER_MID, WIPER_MID}, {4'h0, w1, w2});
        check_val("flags", 24'hc, {20'h0, sdo_oe_n, ready_oe_n, busy, rpm});
        done("reset");
        send(24'hb00100);
        check_val("wiper1", 24'h100, {14'h0, w1});
        check_val("tap 256", 24'h1, {23'h0, t1[256]});
        pol = 1'b1;
        send(24'ha00000);
        send(24'h000000);
        check_val("wiper readback", 24'ha00100, rx[23:0]);
        pol = 1'b0;
        done("write read");
        send(24'hb10000);
        e = WIPER_ZERO;
        for (int i = 0; i < 12; i++) begin
            e = (e == WIPER_ZERO) ? WIPER_ONE : (e >= WIPER_MID) ? WIPER_FULL : {e[8:0], 1'b0};
            send(24'hc10000);
            check_val("log up", {14'h0, e}, {14'h0, w2});
        end
        for (int i = 0; i < 12; i++) begin
            e = e >> 1;
            send(24'h410000);
            check_val("log down", {14'h0, e}, {14'h0, w2});
        end
        send(24'he00000);
        send(24'hf00000);
        send(24'h710000);
        send(24'h600000);
        check_val("steps", 24'h040000, {4'h0, w1, w2});
        send(24'hb00003);
        send(24'hb10300);
        send(24'hd00000);
        check_val("ganged up", 24'h001bff, {4'h0, w1, w2});
        send(24'h500000);
        check_val("ganged down", 24'h000dff, {4'h0, w1, w2});
        done("log taper");
        send(24'h200000);
        save_wait;
        send(24'h32beef);
        save_wait;
        send(24'h920000);
        send(24'h000000);
        check_val("word readback", 24'h92beef, rx[23:0]);
        send(24'hb00155);
        send(24'h800000);
        check_val("reset presets", {4'h0, 10'h003, WIPER_MID}, {4'h0, w1, w2});
        send(24'hb00155);
        send(24'h100000);
        check_val("restore", 24'h007, {13'h0, w1, rpm});
        send(24'h000000);
        check_val("idle mode", 24'h0, {23'h0, rpm});
        done("store");
        @(posedge clock) wp_n <= 1'b0;
        send(24'hb00077);
        check_val("protected", 24'h3, {14'h0, w1});
        @(posedge clock) wp_n <= 1'b1;
        send(24'hb00155);
        @(posedge clock) strobe_n <= 1'b0;
        repeat (6) @(posedge clock);
        #1;
        check_val("strobe low", {4'h0, WIPER_MID, WIPER_MID}, {4'h0, w1, w2});
        @(posedge clock) strobe_n <= 1'b1;
        repeat (6) @(posedge clock);
        #1;
        check_val("strobe high", 24'h3, {14'h0, w1});
        done("protect strobe");
        m_u.xfer({36'h0, 12'hb01}, 12, pol, rx);
        check_val("short frame", 24'h3, {14'h0, w1});
        m_u.xfer(48'h5a5a5a_b10123, 48, pol, rx);
        check_val("chain out", 24'h5a5a5a, rx[23:0]);
        check_val("near word", 24'h123, {14'h0, w2});
        done("chain");
        wrap_up;
    end
endmodule : dual_wiper_serial_command_unit_bench
bind dual_wiper_serial_command_unit dual_wiper_serial_command_unit_asserts #(.NV_SAVE_CYCLES(NV_SAVE_CYCLES)) chk_u (
    .clock(clock), .resetn(resetn), .spi_clk(spi_clk), .cs_n(cs_n), .sdi(sdi), .sdo_out(sdo_out),
    .sdo_oe_n(sdo_oe_n), .ready_out(ready_out), .ready_oe_n(ready_oe_n), .preset_strobe_n(preset_strobe_n),
    .write_protect_n(write_protect_n), .wiper1_code(wiper1_code), .wiper2_code(wiper2_code),
    .wiper1_taps(wiper1_taps), .wiper2_taps(wiper2_taps), .read_power_mode(read_power_mode),
    .save_busy(save_busy));

// ==== verif/spi_master_model.sv ====
`timescale 1ns/1ps
module spi_master_model (
    input  wire logic clock,
    input  wire logic sdo_out,
    input  wire logic sdo_oe_n,
    output logic      spi_clk,
    output logic      cs_n,
    output logic      sdi
);
    logic line;
    // ----
    // Pulled-up SDO wire
    // ----
    assign line = sdo_oe_n ? 1'b1 : sdo_out;
    initial begin
        spi_clk = 1'b0;
        cs_n    = 1'b1;
        sdi     = 1'b0;
    end
    // Idle level is set one cycle before the select
    task automatic xfer(input logic [47:0] w, input int n, input logic pol, output logic [47:0] r);
        r = '0;
        @(posedge clock) spi_clk <= pol;
        @(posedge clock) cs_n <= 1'b0;
        #42;
        for (int i = 0; i < n; i++) begin
            spi_clk <= 1'b0;
            sdi     <= w[n-1-i];
            #80;
            r        = {r[46:0], line};
            spi_clk <= 1'b1;
            #80;
        end
        spi_clk <= pol;
        #40;
        sdi <= ~sdi;
        @(posedge clock) cs_n <= 1'b1;
        repeat (8) @(posedge clock);
        #1;
    endtask : xfer
endmodule : spi_master_model
